//--- logic/hcpp_pkg.sv
// Package for the host control port pin block
package hcpp_pkg;
  localparam int unsigned MCLK_FREQ_HZ     = 200000000;
  localparam int unsigned REF_FREQ_HZ      = 28636360;
  localparam int unsigned RST_MIN_MS       = 5;
  localparam longint unsigned RST_MIN_CYC_L =
    (longint'(RST_MIN_MS) * longint'(MCLK_FREQ_HZ) + 999) / 1000;
  localparam int unsigned RST_MIN_CYC      = 32'(RST_MIN_CYC_L);
  localparam int unsigned EVT_W            = 8;
  localparam logic [6:0]  RX_IO_ADDR_LO    = 7'h4c;
  localparam logic [6:0]  RX_IO_ADDR_HI    = 7'h4d;
  localparam logic [6:0]  TX_MAIN_ADDR_LO  = 7'h72;
  localparam logic [6:0]  TX_MAIN_ADDR_HI  = 7'h7a;
  localparam logic [EVT_W-1:0] EVT_RESET   = 8'h00;

  typedef struct packed {
    logic             active_high;
    logic             mute_select;
    logic [EVT_W-1:0] event_enable;
  } hcpp_irq_cfg_s;

  typedef struct packed {
    logic [6:0] rx_io_addr;
    logic [6:0] tx_main_addr;
  } hcpp_addr_s;
endpackage : hcpp_pkg

//--- logic/hcpp_top.sv
// Host control pins: chip select gating, address select, interrupt outputs, reset filter
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Act on control transactions only while select low
// - Address select sets receiver and transmitter addresses
// - Each general interrupt has selectable polarity
// - Enabled status bit changes assert general interrupt
// - General interrupt pin may carry audio mute
// - Transmitter interrupt only drives low, else released
// - Reset held low 5 ms resets logic
// - Power-down low powers down, high runs
// - Logic clocked from reference clock input
module hcpp_top (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         reset_n_pin,
  input  wire logic                         power_down_n,
  input  wire logic                         chip_select_pin,
  input  wire logic                         slave_addr_select,
  input  wire logic                         ctrl_req,
  output logic                              ctrl_accept,
  output hcpp_pkg::hcpp_addr_s              map_addr,
  output logic                              core_reset,
  output logic                              core_enable,
  input  wire logic [hcpp_pkg::EVT_W-1:0]   status_a,
  input  wire logic [hcpp_pkg::EVT_W-1:0]   status_b,
  input  wire logic [hcpp_pkg::EVT_W-1:0]   clear_a,
  input  wire logic [hcpp_pkg::EVT_W-1:0]   clear_b,
  input  wire hcpp_pkg::hcpp_irq_cfg_s      cfg_a,
  input  wire hcpp_pkg::hcpp_irq_cfg_s      cfg_b,
  input  wire logic                         audio_mute,
  input  wire logic                         tx_irq_req,
  output logic                              general_irq_out_a,
  output logic                              general_irq_out_b,
  output logic [hcpp_pkg::EVT_W-1:0]        pending_a,
  output logic [hcpp_pkg::EVT_W-1:0]        pending_b,
  output logic                              tx_irq_o,
  output logic                              tx_irq_oe_n
);

  // Two-flop synchronisers for every pin input
  // Reset and power pins preset high, so leaving rst is no false pin reset
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  wire  [4:0] pin_raw = {reset_n_pin, power_down_n, chip_select_pin,
                         slave_addr_select, audio_mute};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 5'h18;
      pin_sync_q <= 5'h18;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  wire rst_pin_low = ~pin_sync_q[4];
  wire pwr_up      = pin_sync_q[3];
  wire cs_high     = pin_sync_q[2];
  wire addr_sel_s  = pin_sync_q[1];
  wire mute_s      = pin_sync_q[0];

  // Short glitches on the reset pin are ignored; only a full-width pulse resets
  logic [31:0] rst_cnt_q;
  logic [31:0] rst_cnt_d;
  logic        core_reset_q;
  logic        core_reset_d;
  wire         rst_width_met = (rst_cnt_q >= hcpp_pkg::RST_MIN_CYC - 32'h1);
  wire  [31:0] rst_cnt_inc   = rst_width_met ? rst_cnt_q : rst_cnt_q + 32'h1;

  // Counter saturates, so a pin stuck low cannot wrap round and drop reset
  assign rst_cnt_d    = rst_pin_low ? rst_cnt_inc : 32'h0;
  // Reset stands while the pin stays low and leaves one edge after it rises
  assign core_reset_d = rst_pin_low ? (rst_width_met | core_reset_q) : 1'b0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rst_cnt_q    <= 32'h0;
      core_reset_q <= 1'b1;
    end else begin
      rst_cnt_q    <= rst_cnt_d;
      core_reset_q <= core_reset_d;
    end
  end

  // The reference clock is mclk here; constants use MCLK_FREQ_HZ and the crystal rate REF_FREQ_HZ is unused
  assign core_reset  = core_reset_q;
  // Powered down or held in reset: the core does no work
  assign core_enable = pwr_up & ~core_reset_q;

  // Floating select pin is pulled low outside, so only high refuses
  wire ctrl_gate_open = ~cs_high & core_enable;
  // Refused requests are dropped, nothing is queued for later
  assign ctrl_accept = ctrl_req & ctrl_gate_open;

  // Select level is re-registered so both map addresses switch on one edge
  logic addr_sel_q;
  logic addr_sel_d;

  assign addr_sel_d = addr_sel_s;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_sel_q <= 1'b0;
    end else begin
      addr_sel_q <= addr_sel_d;
    end
  end

  // One decode serves both maps
  function automatic logic [6:0] pick_addr(
    input logic       sel,
    input logic [6:0] addr_lo,
    input logic [6:0] addr_hi
  );
    pick_addr = sel ? addr_hi : addr_lo;
  endfunction

  // Pin level for a logical level under the chosen polarity
  function automatic logic drive_level(
    input logic active_high,
    input logic level_in
  );
    drive_level = active_high ? level_in : ~level_in;
  endfunction

  wire [6:0] rx_io_addr_sel   = pick_addr(addr_sel_q, hcpp_pkg::RX_IO_ADDR_LO,
                                          hcpp_pkg::RX_IO_ADDR_HI);
  wire [6:0] tx_main_addr_sel = pick_addr(addr_sel_q, hcpp_pkg::TX_MAIN_ADDR_LO,
                                          hcpp_pkg::TX_MAIN_ADDR_HI);

  assign map_addr.rx_io_addr   = rx_io_addr_sel;
  assign map_addr.tx_main_addr = tx_main_addr_sel;

  // Per-output change detector, sticky pending, polarity and mute select
  wire  [hcpp_pkg::EVT_W-1:0] stat_in  [2];
  wire  [hcpp_pkg::EVT_W-1:0] clr_in   [2];
  hcpp_pkg::hcpp_irq_cfg_s    cfg_in   [2];
  wire  [hcpp_pkg::EVT_W-1:0] pend_out [2];
  wire  [1:0]                 pin_out;

  assign stat_in[0] = status_a;
  assign stat_in[1] = status_b;
  assign clr_in[0]  = clear_a;
  assign clr_in[1]  = clear_b;
  assign cfg_in[0]  = cfg_a;
  assign cfg_in[1]  = cfg_b;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_irq
      // Each output keeps its own state, so no register has two drivers
      logic [hcpp_pkg::EVT_W-1:0] stat_prev_q;
      logic [hcpp_pkg::EVT_W-1:0] pend_q;
      logic                       pin_q;
      wire  [hcpp_pkg::EVT_W-1:0] enable   = cfg_in[gi].event_enable;
      wire  [hcpp_pkg::EVT_W-1:0] change   = (stat_in[gi] ^ stat_prev_q) & enable;
      // Set beats clear, so an event landing with its clear is not lost
      wire  [hcpp_pkg::EVT_W-1:0] pend_d   = (pend_q & ~clr_in[gi]) | change;
      wire                        irq_act  = |(pend_q & enable);
      // Mute ignores pending; events still collect for later
      wire                        level    = cfg_in[gi].mute_select ? mute_s : irq_act;
      wire                        pin_d    = drive_level(cfg_in[gi].active_high, level);
      wire                        pin_idle = drive_level(cfg_in[gi].active_high, 1'b0);

      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          stat_prev_q <= hcpp_pkg::EVT_RESET;
          pend_q      <= hcpp_pkg::EVT_RESET;
          pin_q       <= 1'b1;
        end else if (core_reset_q) begin
          // Track status so leaving reset raises no stale change
          stat_prev_q <= stat_in[gi];
          pend_q      <= hcpp_pkg::EVT_RESET;
          pin_q       <= pin_idle;
        end else begin
          stat_prev_q <= stat_in[gi];
          pend_q      <= pend_d;
          pin_q       <= pin_d;
        end
      end

      assign pend_out[gi] = pend_q;
      assign pin_out[gi]  = pin_q;
    end
  endgenerate

  assign general_irq_out_a = pin_out[0];
  assign general_irq_out_b = pin_out[1];
  assign pending_a         = pend_out[0];
  assign pending_b         = pend_out[1];

  // Request is registered so the shared line never glitches low
  logic tx_irq_q;
  logic tx_irq_d;

  assign tx_irq_d = tx_irq_req & ~core_reset_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_irq_q <= 1'b0;
    end else begin
      tx_irq_q <= tx_irq_d;
    end
  end

  // Open drain: only ever drive zero; enable is active low
  assign tx_irq_o    = 1'b0;
  assign tx_irq_oe_n = ~tx_irq_q;

endmodule // hcpp_top

`default_nettype wire

//--- testbench/hcpp_host_model.sv
// Host side model of the open-drain transmitter interrupt line
`timescale 1ns/100ps
`default_nettype none
module hcpp_host_model (
  input  wire logic tx_irq_o,
  input  wire logic tx_irq_oe_n,
  output logic      tx_irq_line
);
  // Pull-up gives the idle high level
  assign tx_irq_line = tx_irq_oe_n ? 1'b1 : tx_irq_o;
endmodule // hcpp_host_model
`default_nettype wire

//--- testbench/hcpp_sva.sv
// Checker for the host control pin block
`timescale 1ns/100ps
`default_nettype none
module hcpp_sva (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic                 reset_n_pin,
  input wire logic                 ctrl_req,
  input wire logic                 ctrl_accept,
  input wire logic                 core_enable,
  input wire logic                 core_reset,
  input wire hcpp_pkg::hcpp_addr_s map_addr,
  input wire logic [7:0]           status_a,
  input wire logic [7:0]           clear_a,
  input wire hcpp_pkg::hcpp_irq_cfg_s cfg_a,
  input wire logic [7:0]           pending_a,
  input wire logic                 general_irq_out_a,
  input wire logic                 tx_irq_req,
  input wire logic                 tx_irq_o,
  input wire logic                 tx_irq_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] new_q;
  int         low_q;
  always_ff @(posedge mclk or posedge rst)
    if (rst) new_q <= '0;
    else new_q <= (status_a ^ $past(status_a)) & cfg_a.event_enable & {8{~core_reset}};
  // Pin low time, compared against the minimum pulse
  always_ff @(posedge mclk or posedge rst)
    if (rst) low_q <= 0;
    else if (reset_n_pin) low_q <= 0;
    else low_q <= low_q + 1;
  chk_accept_gated: assert property (ctrl_accept |-> ctrl_req && core_enable)
    else $error("accept while gated");
  chk_addr_pair: assert property (map_addr.rx_io_addr ==
    ((map_addr.tx_main_addr == hcpp_pkg::TX_MAIN_ADDR_HI) ?
    hcpp_pkg::RX_IO_ADDR_HI : hcpp_pkg::RX_IO_ADDR_LO)) else $error("address pair");
  chk_irq_level: assert property (
    !$past(rst) && !cfg_a.mute_select && $stable(cfg_a) |-> general_irq_out_a ==
    (|($past(pending_a) & cfg_a.event_enable) ~^ cfg_a.active_high)) else $error("irq level");
  chk_pend_set: assert property ((new_q & ~pending_a) == 8'h00)
    else $error("pending missed");
  chk_pend_clear: assert property (!$past(core_reset) |->
    (($past(pending_a) & ~pending_a) & ~$past(clear_a)) == 8'h00)
    else $error("pending dropped");
  chk_tx_low: assert property (tx_irq_o == 1'b0) else $error("tx drives high");
  chk_tx_cause: assert property (!tx_irq_oe_n |-> $past(tx_irq_req))
    else $error("tx drive uncaused");
  chk_reset_width: assert property ($rose(core_reset) |-> low_q >= hcpp_pkg::RST_MIN_CYC)
    else $error("short reset taken");
  chk_enable_reset: assert property (core_reset |-> !core_enable)
    else $error("enabled in reset");
endmodule // hcpp_sva
bind hcpp_top hcpp_sva i_sva (
  .mclk(mclk), .rst(rst), .reset_n_pin(reset_n_pin), .ctrl_req(ctrl_req),
  .ctrl_accept(ctrl_accept), .core_enable(core_enable), .core_reset(core_reset),
  .map_addr(map_addr), .status_a(status_a), .clear_a(clear_a), .cfg_a(cfg_a),
  .pending_a(pending_a), .general_irq_out_a(general_irq_out_a),
  .tx_irq_req(tx_irq_req), .tx_irq_o(tx_irq_o), .tx_irq_oe_n(tx_irq_oe_n)
);
`default_nettype wire

//--- testbench/test_hcpp_top.sv
// Self-checking bench for the host control pin block
`timescale 1ns/100ps
`default_nettype none
module test_hcpp_top;
  logic mclk = 0, rst = 1, reset_n_pin = 1, power_down_n = 1, chip_select_pin = 0;
  logic slave_addr_select = 0, ctrl_req = 1, audio_mute = 0, tx_irq_req = 0;
  logic [7:0] status_a = '0, status_b = '0, clear_a = '0, clear_b = '0, pending_a, pending_b;
  hcpp_pkg::hcpp_irq_cfg_s cfg_a = '0, cfg_b = '0;
  hcpp_pkg::hcpp_addr_s map_addr;
  logic ctrl_accept, core_reset, core_enable, general_irq_out_a, general_irq_out_b;
  logic tx_irq_o, tx_irq_oe_n, tx_irq_line;
  int failures = 0, n_compared = 0;
  // Rows are {cs, power-down, select, accept}
  logic [3:0] rows [6] = '{4'h5, 4'hc, 4'h7, 4'h2, 4'ha, 4'h5};
  always #2.5 mclk = ~mclk;
  hcpp_top i_dut (
    .mclk(mclk), .rst(rst), .reset_n_pin(reset_n_pin), .power_down_n(power_down_n),
    .chip_select_pin(chip_select_pin), .slave_addr_select(slave_addr_select),
    .ctrl_req(ctrl_req), .ctrl_accept(ctrl_accept), .map_addr(map_addr),
    .core_reset(core_reset), .core_enable(core_enable), .status_a(status_a),
    .status_b(status_b), .clear_a(clear_a), .clear_b(clear_b), .cfg_a(cfg_a),
    .cfg_b(cfg_b), .audio_mute(audio_mute), .tx_irq_req(tx_irq_req),
    .general_irq_out_a(general_irq_out_a), .general_irq_out_b(general_irq_out_b),
    .pending_a(pending_a), .pending_b(pending_b), .tx_irq_o(tx_irq_o),
    .tx_irq_oe_n(tx_irq_oe_n)
  );
  hcpp_host_model i_host (
    .tx_irq_o(tx_irq_o), .tx_irq_oe_n(tx_irq_oe_n), .tx_irq_line(tx_irq_line)
  );
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic irq(input logic ah);
    cfg_a <= '{ah, 1'b0, 8'h01};
    cfg_b <= '{ah, 1'b0, 8'h01};
    step(4);
    status_a <= ~status_a;
    status_b <= ~status_b;
    step(3);
    #1 chk({pending_a, pending_b, general_irq_out_a, general_irq_out_b}, {16'h0101, ah, ah});
    step(1);
    clear_a <= 8'h01;
    clear_b <= 8'h01;
    step(1);
    clear_a <= 8'h00;
    clear_b <= 8'h00;
    step(3);
    #1 chk({pending_a, pending_b, general_irq_out_a, general_irq_out_b}, {16'h0, ~ah, ~ah});
    $display("irq test done");
  endtask
  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    step(5);
    rst <= 1'b0;
    step(3);
    #1 chk({core_reset, pending_a, tx_irq_oe_n}, {1'b0, 8'h00, 1'b1});
    foreach (rows[i]) begin
      {chip_select_pin, power_down_n, slave_addr_select} <= rows[i][3:1];
      step(4);
      #1 chk({ctrl_accept, core_enable, map_addr}, {rows[i][0], power_down_n,
        slave_addr_select ? {hcpp_pkg::RX_IO_ADDR_HI, hcpp_pkg::TX_MAIN_ADDR_HI} :
        {hcpp_pkg::RX_IO_ADDR_LO, hcpp_pkg::TX_MAIN_ADDR_LO}});
    end
    // Gate open here, so only the missing request can refuse
    ctrl_req <= 1'b0;
    step(1);
    #1 chk(ctrl_accept, 1'b0);
    ctrl_req <= 1'b1;
    $display("row test done");
    irq(1'b1);
    irq(1'b0);
    // Mute is expected as a plain level on the pin
    cfg_a <= '{1'b1, 1'b1, 8'h00};
    for (int m = 1; m >= 0; m--) begin
      audio_mute <= m[0];
      step(5);
      #1 chk(general_irq_out_a, m[0]);
    end
    for (int t = 1; t >= 0; t--) begin
      tx_irq_req <= t[0];
      step(3);
      #1 chk(tx_irq_line, !t[0]);
    end
    // Full pulse is too long to run; a short one must be ignored
    reset_n_pin <= 1'b0;
    step(20);
    reset_n_pin <= 1'b1;
    step(4);
    #1 chk(core_reset, 1'b0);
    $display("pin test done");
    // Second reset in mid-run, then outputs after release
    rst <= 1'b1;
    step(2);
    #1 chk({core_reset, pending_a, general_irq_out_a, general_irq_out_b, tx_irq_oe_n},
      {1'b1, 8'h00, 3'h7});
    rst <= 1'b0;
    step(2);
    #1 chk({core_reset, core_enable, general_irq_out_a, general_irq_out_b},
      {1'b0, 1'b1, 1'b0, 1'b1});
    $display("reset test done");
    wrap_up();
  end
endmodule // test_hcpp_top
`default_nettype wire
